// *** hdl/intc_vectoring.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - primary vector table starts at word address 0x000004.
// - table holds 126 slots: eight traps then 118 interrupt slots.
// - each slot holds a 24-bit service routine start address.
// - lower vector address outranks higher; vector zero outranks all.
// - up to 45 interrupt sources and five traps; other slots reserved.
// - alternate-table select bit 15 of control two moves all fetches.
// - alternate table slot address is primary slot address plus 0x100.
// - reset clears registers; cpu resumes at address zero, no vector.
// - traps are osc fail, address, stack, math, dma at vectors 1-5.
// - peripheral vectors start at 8; vector 8 is external pin zero.
// - each source has a flag set by hardware, cleared by software.
// - a source with enable zero is never forwarded to the cpu.
// - each user source has a writable three-bit priority field.
// - vector number and new level are latched and readable.
// - flag, enable and priority bits follow vector-table order.
// - control one holds nesting disable and traps; two holds edges, alt.
// - thirty software-visible registers in total.
// - cpu level is 3 bits plus top bit; top set or 7 blocks users.
// - each external pin has polarity: one falling edge, zero rising.
// - hard traps are levels 13-15; lower hard trap during higher conflicts.
module intc_vectoring #(
    parameter int NUM_SRC = 68,
    parameter logic [NUM_SRC-1:0] IMPL_MASK = intc_pkg::IMPL_MASK_DEF[NUM_SRC-1:0]
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [NUM_SRC-1:0] i_periph_irq,
    input wire logic [2:0] i_ext_pin_irq,
    input wire logic [4:0] i_trap_evt,
    input wire logic [2:0] i_cpu_priority_level,
    input wire logic i_cpu_level_top_bit,
    output var intc_pkg::vec_out_t o_vec,
    output logic o_nesting_disable,
    output logic o_trap_conflict_flag
);
    // ==========================================================
    // elaboration check
    generate
        if (NUM_SRC < 1 || NUM_SRC > intc_pkg::SRC_MAX) begin : g_bad
            $error("NUM_SRC out of range for the register map");
        end
    endgenerate

    // ==========================================================
    // state
    logic [NUM_SRC-1:0] flags_r, flags_nxt;
    logic [NUM_SRC-1:0] en_r, en_nxt;
    logic [NUM_SRC-1:0][2:0] prio_r, prio_nxt;
    logic [4:0] trap_r, trap_nxt;
    logic nest_r, nest_nxt;
    logic alt_r, alt_nxt;
    logic [2:0] pol_r, pol_nxt;
    logic [6:0] pend_num_r, pend_num_nxt;
    logic [3:0] pend_lvl_r, pend_lvl_nxt;
    logic conflict_r, conflict_nxt;
    logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r;
    intc_pkg::vec_out_t vec_r, vec_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [NUM_SRC-1:0] hw_set;
    logic [2:0] pin_edge;
    logic [5:0] idx;
    logic mapped, wr_en;
    logic [3:0] cpu_lvl;

    assign idx = i_paddr[7:2];
    assign mapped = (i_paddr[1:0] == 2'h0) && (idx <= intc_pkg::REG_PEND);
    assign wr_en = i_psel && i_penable && pready_r && i_pwrite && mapped;
    assign cpu_lvl = {i_cpu_level_top_bit, i_cpu_priority_level};

    // ==========================================================
    // external pins: two-stage sync then edge pick by polarity
    // third stage only holds the previous synced level for edges
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_s3_r <= 3'h0;
        end else begin
            pin_s1_r <= i_ext_pin_irq;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // polarity one means falling edge
    assign pin_edge = (pol_r & pin_s3_r & ~pin_s2_r) | (~pol_r & ~pin_s3_r & pin_s2_r);

    // hardware set terms, reserved slots never set
    always_comb begin
        hw_set = i_periph_irq;
        hw_set[intc_pkg::EXT_IDX0] = i_periph_irq[intc_pkg::EXT_IDX0] | pin_edge[0];
        if (NUM_SRC > intc_pkg::EXT_IDX1) begin
            hw_set[intc_pkg::EXT_IDX1] = i_periph_irq[intc_pkg::EXT_IDX1] | pin_edge[1];
        end
        if (NUM_SRC > intc_pkg::EXT_IDX2) begin
            hw_set[intc_pkg::EXT_IDX2] = i_periph_irq[intc_pkg::EXT_IDX2] | pin_edge[2];
        end
        hw_set = hw_set & IMPL_MASK;
    end

    // ==========================================================
    // register file next values; hardware sets are or-ed last
    always_comb begin
        flags_nxt = flags_r;
        en_nxt = en_r;
        prio_nxt = prio_r;
        trap_nxt = trap_r;
        nest_nxt = nest_r;
        alt_nxt = alt_r;
        pol_nxt = pol_r;
        if (wr_en) begin
            if (idx == intc_pkg::REG_GCTL1) begin
                nest_nxt = i_pwdata[intc_pkg::NEST_BIT];
                for (int t = 0; t < intc_pkg::NUM_TRAP; t++) begin
                    trap_nxt[t] = i_pwdata[intc_pkg::TRAP_BIT[t]];
                end
            end
            if (idx == intc_pkg::REG_GCTL2) begin
                alt_nxt = i_pwdata[intc_pkg::ALT_BIT];
                pol_nxt = i_pwdata[2:0];
            end
            // source s sits in flag/enable word s/16, priority word s/4
            for (int s = 0; s < NUM_SRC; s++) begin
                if (idx == intc_pkg::REG_FLAG0 + 6'(s / 16)) begin
                    flags_nxt[s] = i_pwdata[s % 16];
                end
                if (idx == intc_pkg::REG_EN0 + 6'(s / 16)) begin
                    en_nxt[s] = i_pwdata[s % 16];
                end
                if (idx == intc_pkg::REG_PRIO0 + 6'(s / 4)) begin
                    prio_nxt[s] = i_pwdata[(s % 4) * 4 +: 3];
                end
            end
        end
        // set after write so the event is never lost
        flags_nxt = (flags_nxt | hw_set) & IMPL_MASK;
        en_nxt = en_nxt & IMPL_MASK;
        trap_nxt = trap_nxt | i_trap_evt;
    end

    // ==========================================================
    // arbitration: traps first, then users by level then vector
    logic found;
    logic [3:0] best_lvl;
    logic [6:0] best_num;
    always_comb begin
        found = 1'b0;
        best_lvl = 4'h0;
        best_num = 7'h00;
        // ascending vector order with strict compare keeps the lowest vector
        for (int t = 0; t < intc_pkg::NUM_TRAP; t++) begin
            if (trap_r[t] && intc_pkg::TRAP_LVL[t] > cpu_lvl
                && intc_pkg::TRAP_LVL[t] > best_lvl) begin
                found = 1'b1;
                best_lvl = intc_pkg::TRAP_LVL[t];
                best_num = 7'(t + 1);
            end
        end
        if (!i_cpu_level_top_bit && i_cpu_priority_level != intc_pkg::CPU_LVL_MAX) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                if (flags_r[s] && en_r[s] && IMPL_MASK[s]
                    && {1'b0, prio_r[s]} > cpu_lvl && {1'b0, prio_r[s]} > best_lvl) begin
                    found = 1'b1;
                    best_lvl = {1'b0, prio_r[s]};
                    best_num = intc_pkg::USER_VEC_BASE + 7'(s);
                end
            end
        end
    end

    // slot address: table base plus two words per vector
    always_comb begin
        vec_nxt.req = found;
        vec_nxt.num = found ? best_num : 7'h00;
        vec_nxt.level = found ? best_lvl : 4'h0;
        vec_nxt.addr = intc_pkg::RESET_ADDR;
        if (found) begin
            vec_nxt.addr = (alt_r ? intc_pkg::ALTERNATE_BASE : intc_pkg::PRIMARY_BASE)
                + {16'h0000, best_num, 1'b0};
        end
        pend_num_nxt = found ? best_num : pend_num_r;
        pend_lvl_nxt = found ? best_lvl : pend_lvl_r;
    end

    // lower hard trap while a higher hard trap is in service
    always_comb begin
        conflict_nxt = conflict_r;
        for (int t = 0; t < intc_pkg::NUM_TRAP; t++) begin
            if (i_trap_evt[t] && intc_pkg::TRAP_LVL[t] >= intc_pkg::HARD_TRAP_MIN
                && cpu_lvl >= intc_pkg::HARD_TRAP_MIN && cpu_lvl > intc_pkg::TRAP_LVL[t]) begin
                conflict_nxt = 1'b1;
            end
        end
    end

    // ==========================================================
    // apb slave: one wait state, data and error land with pready
    always_comb begin
        pready_nxt = i_psel && i_penable && !pready_r;
        pslverr_nxt = pready_nxt && !mapped;
        prdata_nxt = 32'h0000_0000;
        if (pready_nxt && mapped && !i_pwrite) begin
            if (idx == intc_pkg::REG_GCTL1) begin
                prdata_nxt[intc_pkg::NEST_BIT] = nest_r;
                for (int t = 0; t < intc_pkg::NUM_TRAP; t++) begin
                    prdata_nxt[intc_pkg::TRAP_BIT[t]] = trap_r[t];
                end
            end
            if (idx == intc_pkg::REG_GCTL2) begin
                prdata_nxt[intc_pkg::ALT_BIT] = alt_r;
                prdata_nxt[2:0] = pol_r;
            end
            if (idx == intc_pkg::REG_PEND) begin
                prdata_nxt[6:0] = pend_num_r;
                prdata_nxt[intc_pkg::LVL_LSB +: 4] = pend_lvl_r;
            end
            for (int s = 0; s < NUM_SRC; s++) begin
                if (idx == intc_pkg::REG_FLAG0 + 6'(s / 16)) begin
                    prdata_nxt[s % 16] = flags_r[s];
                end
                if (idx == intc_pkg::REG_EN0 + 6'(s / 16)) begin
                    prdata_nxt[s % 16] = en_r[s];
                end
                if (idx == intc_pkg::REG_PRIO0 + 6'(s / 4)) begin
                    prdata_nxt[(s % 4) * 4 +: 3] = prio_r[s];
                end
            end
        end
    end

    // ==========================================================
    // all state registers except the pin sync stages; reset clears everything
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flags_r <= '0;
            en_r <= '0;
            prio_r <= '0;
            trap_r <= 5'h00;
            nest_r <= 1'b0;
            alt_r <= 1'b0;
            pol_r <= 3'h0;
            pend_num_r <= 7'h00;
            pend_lvl_r <= 4'h0;
            conflict_r <= 1'b0;
            vec_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            flags_r <= flags_nxt;
            en_r <= en_nxt;
            prio_r <= prio_nxt;
            trap_r <= trap_nxt;
            nest_r <= nest_nxt;
            alt_r <= alt_nxt;
            pol_r <= pol_nxt;
            pend_num_r <= pend_num_nxt;
            pend_lvl_r <= pend_lvl_nxt;
            conflict_r <= conflict_nxt;
            vec_r <= vec_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign o_vec = vec_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_prdata = prdata_r;
    assign o_nesting_disable = nest_r;
    assign o_trap_conflict_flag = conflict_r;

    // ==========================================================
    // checks
    property p_reset_vec;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !vec_r.req |-> vec_r.addr == 24'h000000 && vec_r.num == 7'h00;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("idle vector not zero");
    property p_primary_addr;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req && !$past(alt_r) |-> vec_r.addr == 24'h000004 + {16'h0000, vec_r.num, 1'b0};
    endproperty
    a_primary_addr: assert property (p_primary_addr) else $error("primary slot address wrong");
    property p_alt_addr;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req && $past(alt_r) |-> vec_r.addr == 24'h000104 + {16'h0000, vec_r.num, 1'b0};
    endproperty
    a_alt_addr: assert property (p_alt_addr) else $error("alternate slot address wrong");
    property p_enable_gate;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req && vec_r.num >= 7'h08 |-> $past(en_r[vec_nxt.num - 7'h08]) // winner as chosen
            && $past(flags_r[vec_nxt.num - 7'h08]);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("disabled source forwarded");

    property p_user_above_cpu;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req && vec_r.num >= 7'h08 |-> !$past(i_cpu_level_top_bit)
            && vec_r.level > $past(cpu_lvl) && $past(i_cpu_priority_level) != 3'h7;
    endproperty
    a_user_above_cpu: assert property (p_user_above_cpu) else $error("user beats cpu level");

    property p_flag_sticky;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ##1 (($past(hw_set) & ~flags_r) == '0);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("hardware set lost");

    property p_trap_vec;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req && vec_r.num < 7'h08 |-> vec_r.num >= 7'h01 && vec_r.num <= 7'h05
            && vec_r.level == 4'hF - {1'b0, vec_r.num[2:0]};
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector or level wrong");

    property p_pend_latch;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        vec_r.req |-> pend_num_r == vec_r.num && pend_lvl_r == vec_r.level;
    endproperty
    a_pend_latch: assert property (p_pend_latch) else $error("pending fields not latched");
endmodule : intc_vectoring
`default_nettype wire

// *** inc/intc_pkg.sv ***
`default_nettype none
package intc_pkg;
    // ==========================================================
    // vector table layout (program-memory word addresses)
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] PRIMARY_BASE = 24'h000004;
    localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
    localparam logic [6:0] USER_VEC_BASE = 7'h08;
    localparam int NUM_TRAP = 5;
    localparam int SRC_MAX = 68;
    // implemented user sources, bit n is vector n+8
    localparam logic [67:0] IMPL_MASK_DEF = 68'hE_E600_601F_FFDF_7FFF;
    // external pin source indices (vectors 8, 28, 37)
    localparam int EXT_IDX0 = 0;
    localparam int EXT_IDX1 = 20;
    localparam int EXT_IDX2 = 29;
    // trap levels, index 0 = oscillator failure .. 4 = dma error
    localparam logic [4:0][3:0] TRAP_LVL = {4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    // trap status bit position in control one, per trap index
    localparam logic [4:0][3:0] TRAP_BIT = {4'h5, 4'h4, 4'h2, 4'h3, 4'h1};
    localparam logic [3:0] HARD_TRAP_MIN = 4'hD;
    localparam logic [2:0] CPU_LVL_MAX = 3'h7;
    // ==========================================================
    // register word indices, byte address = index * 4
    localparam logic [5:0] REG_GCTL1 = 6'h00;
    localparam logic [5:0] REG_GCTL2 = 6'h01;
    localparam logic [5:0] REG_FLAG0 = 6'h02;
    localparam logic [5:0] REG_EN0 = 6'h07;
    localparam logic [5:0] REG_PRIO0 = 6'h0C;
    localparam logic [5:0] REG_PEND = 6'h1D;
    localparam int NUM_FLAG_REGS = 5;
    localparam int NUM_PRIO_REGS = 17;
    localparam int NEST_BIT = 15;
    localparam int ALT_BIT = 15;
    localparam int LVL_LSB = 8;
    // ==========================================================
    // vector handed to the cpu core
    typedef struct packed {
        logic req;
        logic [6:0] num;
        logic [3:0] level;
        logic [23:0] addr;
    } vec_out_t;
endpackage : intc_pkg
`default_nettype wire

// *** tb/cpu_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// cpu core side: running level and the last fetched slot
module cpu_core_model (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_want_level,
    input wire intc_pkg::vec_out_t i_vec,
    output logic [2:0] o_level,
    output logic o_top,
    output logic [23:0] o_fetch_addr
);
    // level only moves on an edge, as a status write in the core would
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_level <= 3'h0;
            o_top <= 1'b0;
            o_fetch_addr <= 24'h000000;
        end else begin
            o_level <= i_want_level[2:0];
            o_top <= i_want_level[3];
            if (i_vec.req) begin
                o_fetch_addr <= i_vec.addr;
            end
        end
    end
endmodule : cpu_core_model
`default_nettype wire

// *** tb/interrupt_vectoring_priority_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module interrupt_vectoring_priority_tb;
    // ==========================================================
    // design hookup and reference state
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00001454;
    logic pready, pslverr, err, top, nest, conflict;
    logic [67:0] irq = 68'h0, m;
    logic [2:0] pins = 3'h0, lvl;
    logic [4:0] trap = 5'h0;
    logic [3:0] want = 4'h0;
    logic [23:0] fetch;
    intc_pkg::vec_out_t vec;
    int flg[68], ena[68], pri[68], trf[5], alt, cpu, s, bad_count, checked;
    int ridx[6] = '{0, 1, 2, 7, 12, 29};
    int ext_idx[3] = '{intc_pkg::EXT_IDX0, intc_pkg::EXT_IDX1, intc_pkg::EXT_IDX2};

    // free running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    intc_vectoring i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_periph_irq(irq),
        .i_ext_pin_irq(pins), .i_trap_evt(trap), .i_cpu_priority_level(lvl),
        .i_cpu_level_top_bit(top), .o_vec(vec), .o_nesting_disable(nest),
        .o_trap_conflict_flag(conflict));
    cpu_core_model i_cpu (.i_ref_clk(clk), .i_sys_rst(rst), .i_want_level(want),
        .i_vec(vec), .o_level(lvl), .o_top(top), .o_fetch_addr(fetch));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xr();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xr

    // register image from the reference arrays, 16 sources a flag or enable word, 4 a priority word
    function automatic logic [31:0] pack_word(int idx);
        logic [31:0] w;
        int b0;
        w = 32'h0;
        for (int b = 0; b < 16; b++) begin
            b0 = (idx - (idx < 7 ? 2 : 7)) * 16 + b;
            if (idx < 12 && b0 < 68) w[b] = (idx < 7) ? flg[b0][0] : ena[b0][0];
            b0 = (idx - 12) * 4 + b;
            if (idx >= 12 && b < 4 && b0 < 68) w[b * 4 +: 3] = pri[b0][2:0];
        end
        return w;
    endfunction : pack_word

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // one apb transfer; hold keeps request lines high across the access
    task automatic apb(input logic w, input int idx, input logic [31:0] d,
                       input logic [67:0] hold);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 8'(idx * 4);
        pwdata <= d;
        irq <= hold;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        irq <= 68'h0;
        if (n >= 50) begin
            bad_count++;
            final_report();
        end
    endtask : apb

    task automatic set_src(input int sx, input int e, input int p);
        ena[sx] = e;
        pri[sx] = p;
        apb(1'b1, 7 + sx / 16, pack_word(7 + sx / 16), 68'h0);
        apb(1'b1, 12 + sx / 4, pack_word(12 + sx / 4), 68'h0);
    endtask : set_src

    // one-clock request pulse; unimplemented slots never set a flag
    task automatic pulse(input logic [67:0] mk, input logic [4:0] tk);
        @(posedge clk);
        irq <= mk;
        trap <= tk;
        @(posedge clk);
        irq <= 68'h0;
        trap <= 5'h0;
        for (int j = 0; j < 68; j++) if (mk[j] && intc_pkg::IMPL_MASK_DEF[j]) flg[j] = 1;
        for (int k = 0; k < 5; k++) if (tk[k]) trf[k] = 1;
    endtask : pulse

    task automatic clear_flags();
        for (int g = 2; g < 7; g++) apb(1'b1, g, 32'h0, 68'h0);
        apb(1'b1, 0, 32'h0, 68'h0);
        foreach (flg[j]) flg[j] = 0;
        foreach (trf[k]) trf[k] = 0;
    endtask : clear_flags

    // winner: highest level, ties to the lowest vector; traps sit below 8
    task automatic expect_vec();
        int best, num, lv;
        logic [35:0] e;
        best = 0;
        num = 0;
        for (int k = 0; k < 5; k++) begin
            lv = int'(intc_pkg::TRAP_LVL[k]);
            if (trf[k] != 0 && lv > cpu && lv > best) begin
                best = lv;
                num = k + 1;
            end
        end
        for (int j = 0; j < 68; j++) begin
            if (cpu < 7 && flg[j] != 0 && ena[j] != 0 && pri[j] > cpu && pri[j] > best) begin
                best = pri[j];
                num = j + 8;
            end
        end
        e = 36'h0;
        if (num != 0) e = {1'b1, 7'(num), 4'(best), 24'(alt * 256 + 4 + 2 * num)};
        repeat (4) @(posedge clk);
        check("vector", vec, e);
        if (num != 0) begin
            check("fetch address", fetch, e[23:0]);
        end
    endtask : expect_vec

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 32'h0, 68'h0);
            check("reset register", rd, 36'h0);
            check("reset error", err, 36'h0);
        end
        check("reset vector", vec, 36'h0);
        check("reset nesting", nest, 36'h0);
        apb(1'b0, 30, 32'h0, 68'h0);
        check("unmapped error", err, 36'h1);
        check("unmapped data", rd, 36'h0);
        set_src(0, 1, 5);
        pulse(68'h1, 5'h0);
        expect_vec();
        apb(1'b0, 29, 32'h0, 68'h0);
        check("pending", rd, 36'h508);
        set_src(0, 0, 5);
        expect_vec();
        // source 1 keeps requesting while software clears its word
        apb(1'b1, 2, 32'h0, 68'h2);
        flg[0] = 0;
        flg[1] = 1;
        apb(1'b0, 2, 32'h0, 68'h0);
        check("set beats clear", rd, 36'h2);
        clear_flags();
        // random sources, levels, table select and cpu level
        for (int it = 0; it < 24; it++) begin
            m = 68'h0;
            for (int j = 0; j < 3; j++) begin
                s = int'(xr() % 68);
                set_src(s, int'(xr() % 4 != 0), int'(xr() % 8));
                m[s] = 1'b1;
            end
            cpu = int'(xr() % 9);
            want <= 4'(cpu);
            alt = int'(xr() % 2);
            apb(1'b1, 1, 32'(alt * 32768), 68'h0);
            pulse(m, 5'h0);
            expect_vec();
            apb(1'b0, 2 + s / 16, 32'h0, 68'h0);
            check("flag word", rd, pack_word(2 + s / 16));
            clear_flags();
        end
        want <= 4'h0;
        cpu = 0;
        for (int k = 0; k < 5; k++) begin
            pulse(68'h0, 5'(1 << k));
            expect_vec();
            apb(1'b0, 0, 32'h0, 68'h0);
            check("trap status", rd[intc_pkg::TRAP_BIT[k]], 36'h1);
            clear_flags();
        end
        pulse(68'h1, 5'h1F);
        expect_vec();
        check("no conflict", conflict, 36'h0);
        apb(1'b1, 0, 32'h00008000, 68'h0);
        repeat (2) @(posedge clk);
        check("nesting", nest, 36'h1);
        // falling polarity first, then rising; the other edge must stay silent
        for (int q = 1; q >= 0; q--) begin
            apb(1'b1, 1, 32'(alt * 32768 + q * 7), 68'h0);
            clear_flags();
            for (int p = 0; p < 3; p++) begin
                set_src(ext_idx[p], 1, 3);
                @(posedge clk);
                pins[p] <= 1'b1;
                flg[ext_idx[p]] = 1 - q;
                repeat (4) @(posedge clk);
                expect_vec();
                clear_flags();
                pins[p] <= 1'b0;
                flg[ext_idx[p]] = q;
                repeat (4) @(posedge clk);
                expect_vec();
                clear_flags();
            end
        end
        want <= 4'hE;
        pulse(68'h0, 5'h02);
        repeat (4) @(posedge clk);
        check("trap conflict", conflict, 36'h1);
        // second reset in mid-run clears the sticky state
        rst <= 1'b1;
        want <= 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("conflict after reset", conflict, 36'h0);
        check("vector after reset", vec, 36'h0);
        final_report();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule : interrupt_vectoring_priority_tb
`default_nettype wire
